/* trl_rate_limiter.sv */
// transmit rate limiter with inter-packet gap stretching and sticky flags
`timescale 1ns/1ps
`include "trl_defs.svh"
// Functional notes
// - overhead, payload-rate and frame-rate methods each enabled separately
// - several methods enabled without accumulate: extra gap is the largest
// - accumulate with only overhead and payload-rate: extra gaps are summed
// - preamble select 0 keeps preamble bytes out of payload length
// - header select 1 subtracts header byte count from payload length
// - header byte count is one global setting
// - length adjustments do not touch the overhead method
// - overhead and payload-rate gaps scaled by two to the exponent, 1 up to 32768
// - overhead method uses compensation value as minimum gap, 13 to 255
// - payload gap is 2^S times 256 over ratio times length
// - sent gap is 12 standard bytes plus the extra gap
// - fractional remainder of payload-rate gap carries to the next frame
// - spacing counter loads start value when payload begins
// - spacing counter drops by one per counted payload byte
// - at frame end a count above 12 extends the next gap
// - sticky flags for cell buffer overflow and underrun
// - sticky flag when any method lengthens a gap
module trl_rate_limiter #(
  parameter int ratio_width = 19,
  parameter int start_width = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire trl_pkg::trl_byte_type in_byte,
  output logic in_ready,
  output trl_pkg::trl_byte_type out_byte,
  input wire logic out_ready,
  input wire logic buf_overflow,
  input wire logic buf_underrun
);
  trl_pkg::trl_mode_type mode;
  logic [7:0] gap_comp;
  logic [ratio_width-1:0] ratio;
  logic [start_width-1:0] frm_start;
  logic [15:0] hdr_count;
  logic [2:0] sticky;
  trl_pkg::trl_state_type state;
  logic [15:0] pay_len;
  logic [15:0] byte_idx;
  logic [start_width-1:0] spacing;
  logic [ratio_width-1:0] frac;
  logic [19:0] gap_left;
  // apb decode
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire hit_mode = paddr == `TRL_MODE_OFS;
  wire hit_ovh = paddr == `TRL_OVH_OFS;
  wire hit_ratio = paddr == `TRL_RATIO_OFS;
  wire hit_start = paddr == `TRL_START_OFS;
  wire hit_hdr = paddr == `TRL_HDR_OFS;
  wire hit_sticky = paddr == `TRL_STICKY_OFS;
  wire hit_status = paddr == `TRL_STATUS_OFS;
  wire hit_any = hit_mode | hit_ovh | hit_ratio | hit_start | hit_hdr
    | hit_sticky | hit_status;
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;
  wire [31:0] mode_word = {20'h0, mode.scale, 2'h0, mode.hdr, mode.pream,
    mode.accum, mode.frm_en, mode.pay_en, mode.ovh_en};
  wire [31:0] rd_mux = hit_mode ? mode_word
    : hit_ovh ? {24'h0, gap_comp}
    : hit_ratio ? 32'(ratio)
    : hit_start ? 32'(frm_start)
    : hit_hdr ? {16'h0, hdr_count}
    : hit_sticky ? {29'h0, sticky}
    : hit_status ? {12'h0, gap_left}
    : 32'h0;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mode <= '0;
      gap_comp <= `TRL_MIN_GAP;
      ratio <= ratio_width'(`TRL_RATIO_RST);
      frm_start <= '0;
      hdr_count <= '0;
    end
    else if (wr)
    begin
      if (hit_mode)
        mode <= {pwdata[`TRL_BIT_OVH_EN], pwdata[`TRL_BIT_PAY_EN],
          pwdata[`TRL_BIT_FRM_EN], pwdata[`TRL_BIT_ACCUM],
          pwdata[`TRL_BIT_PREAM], pwdata[`TRL_BIT_HDR],
          pwdata[`TRL_SCALE_LSB+3:`TRL_SCALE_LSB]};
      if (hit_ovh)
        gap_comp <= pwdata[7:0];
      if (hit_ratio)
        ratio <= pwdata[ratio_width-1:0];
      if (hit_start)
        frm_start <= pwdata[start_width-1:0];
      if (hit_hdr)
        hdr_count <= pwdata[15:0];
    end
  // stream: bytes pass straight through while not in a gap
  wire in_gap = state == trl_pkg::st_gap;
  assign in_ready = out_ready && !in_gap;
  wire take = in_byte.valid && in_ready;
  wire [15:0] pream_skip = mode.pream ? 16'h0 : `TRL_PREAM_BYTES;
  wire [15:0] hdr_skip = mode.hdr ? hdr_count : 16'h0;
  wire [15:0] skip = pream_skip + hdr_skip;
  wire counted = take && (byte_idx >= skip);
  wire pay_start = take && (byte_idx == skip);
  wire [15:0] len_now = counted ? pay_len + 16'd1 : pay_len;
  // payload-rate gap in units of 1/ratio bytes, remainder carried
  wire [47:0] pay_num = ({32'h0, len_now} << (5'(mode.scale) + 5'd8))
    + 48'(frac);
  wire [47:0] pay_q = pay_num / 48'(ratio);
  wire [47:0] pay_r = pay_num % 48'(ratio);
  wire [19:0] pay_gap = mode.pay_en ? pay_q[19:0] : 20'h0;
  wire [19:0] ovh_raw = 20'(gap_comp) > `TRL_STD_IPG
    ? 20'(gap_comp) - `TRL_STD_IPG : 20'h0;
  wire [19:0] ovh_gap = mode.ovh_en
    ? 20'(ovh_raw << mode.scale) : 20'h0;
  wire [start_width-1:0] spc_now = pay_start ? frm_start - 1'b1
    : counted ? spacing - 1'b1 : spacing;
  wire [19:0] frm_gap = (mode.frm_en && 20'(spc_now) > `TRL_STD_IPG)
    ? 20'(spc_now) : 20'h0;
  wire sum_mode = mode.accum && !mode.frm_en;
  wire [19:0] max_op = ovh_gap > pay_gap ? ovh_gap : pay_gap;
  wire [19:0] max3 = max_op > frm_gap ? max_op : frm_gap;
  wire [19:0] extra = sum_mode ? ovh_gap + pay_gap : max3;
  wire frame_end = take && in_byte.eof;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state <= trl_pkg::st_idle;
      pay_len <= '0;
      byte_idx <= '0;
      spacing <= '0;
      frac <= '0;
      gap_left <= '0;
    end
    else
    begin
      unique case (state)
        trl_pkg::st_idle, trl_pkg::st_frame:
        begin
          if (take)
          begin
            byte_idx <= byte_idx + 16'd1;
            pay_len <= len_now;
            spacing <= spc_now;
            state <= trl_pkg::st_frame;
          end
          if (frame_end)
          begin
            gap_left <= `TRL_STD_IPG + extra;
            if (mode.pay_en)
              frac <= pay_r[ratio_width-1:0];
            byte_idx <= '0;
            pay_len <= '0;
            state <= trl_pkg::st_gap;
          end
        end
        trl_pkg::st_gap:
        begin
          gap_left <= gap_left - 20'd1;
          if (gap_left <= 20'd1)
            state <= trl_pkg::st_idle;
        end
      endcase
    end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      out_byte <= '0;
    else if (out_ready || !out_byte.valid)
      out_byte <= take ? in_byte : '0;
  // pin-level error inputs pass two flops before use
  logic [1:0] err_s1;
  logic [1:0] err_s2;
  logic [1:0] err_s3;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      err_s1 <= '0;
      err_s2 <= '0;
      err_s3 <= '0;
    end
    else
    begin
      err_s1 <= {buf_underrun, buf_overflow};
      err_s2 <= err_s1;
      err_s3 <= err_s2;
    end
  wire [1:0] err_rise = err_s2 & ~err_s3;
  wire rlim_evt = frame_end && (extra != 20'h0);
  wire [2:0] set_v = {rlim_evt, err_rise};
  wire [2:0] clr_v = (wr && hit_sticky) ? pwdata[2:0] : 3'h0;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sticky <= '0;
    else
      sticky <= set_v | (sticky & ~clr_v);
  // checks on gap length, spacing counter and sticky flags
  default clocking trl_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_sticky_set_wins: assert property (
    set_v[2] |=> sticky[2])
    else $error("rate flag lost");

  a_gap_holds_input: assert property (
    frame_end |=> !in_ready)
    else $error("no gap after frame");

  a_gap_length: assert property (
    frame_end |=> gap_left == `TRL_STD_IPG + $past(extra))
    else $error("gap length wrong");

  a_sum_mode: assert property (
    frame_end && sum_mode
    |=> gap_left == `TRL_STD_IPG + $past(ovh_gap) + $past(pay_gap))
    else $error("sum wrong");

  a_max_mode: assert property (
    !sum_mode |-> extra >= ovh_gap && extra >= pay_gap && extra >= frm_gap)
    else $error("max wrong");

  a_spacing_load: assert property (
    pay_start && !in_byte.eof |=> spacing == $past(frm_start) - 1'b1)
    else $error("spacing not loaded");

  a_spacing_dec: assert property (
    counted && !pay_start && !in_byte.eof
    |=> spacing == $past(spacing) - 1'b1)
    else $error("spacing not decremented");

  a_frm_small: assert property (
    20'(spc_now) <= `TRL_STD_IPG |-> frm_gap == 20'h0)
    else $error("small count extended");

  a_ovh_off: assert property (
    !mode.ovh_en |-> ovh_gap == 20'h0)
    else $error("overhead leak");

  a_oflw_flag: assert property (
    err_rise[0] |=> sticky[0])
    else $error("overflow flag lost");

  a_uflw_flag: assert property (
    err_rise[1] |=> sticky[1])
    else $error("underrun flag lost");

  a_oflw_hold: assert property (
    sticky[0] && !clr_v[0] |=> sticky[0])
    else $error("overflow flag dropped");

  a_uflw_hold: assert property (
    sticky[1] && !clr_v[1] |=> sticky[1])
    else $error("underrun flag dropped");

  a_rate_hold: assert property (
    sticky[2] && !clr_v[2] |=> sticky[2])
    else $error("rate flag dropped");

  a_rate_quiet: assert property (
    !rlim_evt && !sticky[2] |=> !sticky[2])
    else $error("rate flag without stretch");

  a_pay_off: assert property (
    !mode.pay_en |-> pay_gap == 20'h0)
    else $error("payload gap leak");

  a_frm_off: assert property (
    !mode.frm_en |-> frm_gap == 20'h0)
    else $error("spacing gap leak");

  a_ovh_value: assert property (
    mode.ovh_en && mode.scale == 4'h0 && gap_comp > 8'd12
    |-> ovh_gap == 20'(gap_comp) - `TRL_STD_IPG)
    else $error("overhead gap wrong");

  a_gap_end: assert property (
    in_gap && gap_left <= 20'd1 |=> !in_gap)
    else $error("gap overruns");

  a_gap_stay: assert property (
    in_gap && gap_left > 20'd1 |=> in_gap)
    else $error("gap cut short");

  a_no_take_gap: assert property (
    in_gap |-> !take)
    else $error("byte taken in gap");

  a_frac_kept: assert property (
    frame_end && !mode.pay_en |=> frac == $past(frac))
    else $error("remainder lost");

  a_len_clear: assert property (
    frame_end |=> pay_len == 16'h0 && byte_idx == 16'h0)
    else $error("length not cleared");

  a_pream_skip: assert property (
    mode.pream |-> pream_skip == 16'h0)
    else $error("preamble skipped");

  a_hdr_skip: assert property (
    !mode.hdr |-> hdr_skip == 16'h0)
    else $error("header skipped");
endmodule

/* trl_defs.svh */
// register offsets, field positions, reset values and timing constants
`ifndef TRL_DEFS_SVH
`define TRL_DEFS_SVH
`define TRL_MODE_OFS 12'h000
`define TRL_OVH_OFS 12'h004
`define TRL_RATIO_OFS 12'h008
`define TRL_START_OFS 12'h00c
`define TRL_HDR_OFS 12'h010
`define TRL_STICKY_OFS 12'h014
`define TRL_STATUS_OFS 12'h018
`define TRL_BIT_OVH_EN 0
`define TRL_BIT_PAY_EN 1
`define TRL_BIT_FRM_EN 2
`define TRL_BIT_ACCUM 3
`define TRL_BIT_PREAM 4
`define TRL_BIT_HDR 5
`define TRL_SCALE_LSB 8
`define TRL_BIT_OFLW 0
`define TRL_BIT_UFLW 1
`define TRL_BIT_RLIM 2
`define TRL_MIN_GAP 8'd13
`define TRL_STD_IPG 20'd12
`define TRL_RATIO_RST 19'd1152
`define TRL_PREAM_BYTES 16'd8
`endif

/* trl_pkg.sv */
// types shared by the transmit rate limiter
package trl_pkg;
  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } trl_byte_type;
  typedef struct packed {
    logic ovh_en;
    logic pay_en;
    logic frm_en;
    logic accum;
    logic pream;
    logic hdr;
    logic [3:0] scale;
  } trl_mode_type;
  typedef enum logic [1:0] {st_idle, st_frame, st_gap} trl_state_type;
endpackage

/* trl_frame_partner.sv */
// frame source and gap meter standing in for the queue system side
`timescale 1ns/1ps
module trl_frame_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic in_ready,
  output trl_pkg::trl_byte_type in_byte,
  output logic busy,
  output logic [15:0] gap
);
  logic [7:0] idx;
  logic gapping;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      in_byte <= '0;
      busy <= 1'b0;
      gap <= '0;
      idx <= '0;
      gapping <= 1'b0;
    end
    else if (go && !busy)
    begin
      busy <= 1'b1;
      gap <= '0;
      idx <= 8'h01;
      in_byte <= '{1'b1, 1'b1, len == 8'h01, 8'h00};
    end
    else if (in_byte.valid && in_ready && in_byte.eof)
    begin
      // released data line shows the inverse, not the last byte
      in_byte <= '{1'b0, 1'b0, 1'b0, ~in_byte.data};
      gapping <= 1'b1;
    end
    else if (in_byte.valid && in_ready)
    begin
      in_byte <= '{1'b1, 1'b0, idx + 8'h01 == len, idx};
      idx <= idx + 8'h01;
    end
    else if (gapping && !in_ready)
    begin
      gap <= gap + 16'h0001;
      in_byte.data <= ~in_byte.data;
    end
    else if (gapping)
    begin
      gapping <= 1'b0;
      busy <= 1'b0;
    end
endmodule

/* tb_trl_rate_limiter.sv */
// testbench for the transmit rate limiter
`timescale 1ns/1ps
module tb_trl_rate_limiter;
  typedef struct packed {
    logic [11:0] mode;
    logic [7:0] ovh;
    logic [15:0] start;
    logic [7:0] len;
    logic [15:0] gap;
  } trl_row_type;
  logic pclk, presetn, psel, penable, pwrite, go, out_ready;
  logic buf_overflow, buf_underrun, pready, pslverr, in_ready, busy, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] len;
  logic [15:0] gap;
  trl_pkg::trl_byte_type in_byte, out_byte;
  int fail_count = 0;
  int samples_checked = 0;
  // ratio 2048 and header 8 throughout; mode, overhead, start per row
  trl_row_type rows [18] = '{
    '{12'h000, 8'd20, 16'd40, 8'd16, 16'd12},
    '{12'h001, 8'd20, 16'd40, 8'd16, 16'd20},
    '{12'h001, 8'd255, 16'd40, 8'd16, 16'd255},
    '{12'h001, 8'd13, 16'd40, 8'd16, 16'd13},
    '{12'h201, 8'd20, 16'd40, 8'd16, 16'd44},
    '{12'ha01, 8'd13, 16'd40, 8'd16, 16'd1036},
    '{12'h002, 8'd20, 16'd40, 8'd16, 16'd13},
    '{12'h012, 8'd20, 16'd40, 8'd16, 16'd14},
    '{12'h032, 8'd20, 16'd40, 8'd16, 16'd13},
    '{12'h031, 8'd20, 16'd40, 8'd16, 16'd20},
    '{12'h014, 8'd20, 16'd40, 8'd16, 16'd36},
    '{12'h004, 8'd20, 16'd40, 8'd16, 16'd44},
    '{12'h014, 8'd20, 16'd20, 8'd16, 16'd12},
    '{12'h015, 8'd20, 16'd40, 8'd16, 16'd36},
    '{12'h013, 8'd20, 16'd40, 8'd16, 16'd20},
    '{12'h01b, 8'd20, 16'd40, 8'd16, 16'd22},
    '{12'h01f, 8'd20, 16'd40, 8'd16, 16'd36},
    '{12'h203, 8'd20, 16'd40, 8'd16, 16'd44}};
  trl_rate_limiter trl_rate_limiter_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .in_byte,
    .in_ready, .out_byte, .out_ready, .buf_overflow, .buf_underrun);
  trl_frame_partner trl_frame_partner_inst (.pclk, .presetn, .go, .len,
    .in_ready, .in_byte, .busy, .gap);
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      test_done();
    end
  endtask
  task automatic frame(input logic [7:0] n);
    int k;
    len <= n;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (busy !== 1'b0 && k < 3000);
    if (k >= 3000)
    begin
      fail_count++;
      test_done();
    end
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, go, buf_overflow, buf_underrun} = '0;
    out_ready = 1'b1;
    paddr = '0;
    pwdata = '0;
    len = 8'h10;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0, rd, err);
    chk(rd, 32'd13);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk(rd, 32'd1152);
    apb(1'b0, 12'h01c, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h008, 32'd2048, rd, err);
    apb(1'b1, 12'h010, 32'd8, rd, err);
    foreach (rows[i])
    begin
      apb(1'b1, 12'h000, {20'h0, rows[i].mode}, rd, err);
      apb(1'b1, 12'h004, {24'h0, rows[i].ovh}, rd, err);
      apb(1'b1, 12'h00c, {16'h0, rows[i].start}, rd, err);
      frame(rows[i].len);
      chk({16'h0, gap}, {16'h0, rows[i].gap});
    end
    apb(1'b0, 12'h014, 32'h0, rd, err);
    chk(rd, 32'h4);
    apb(1'b1, 12'h014, 32'h7, rd, err);
    apb(1'b0, 12'h014, 32'h0, rd, err);
    chk(rd, 32'h0);
    for (int b = 0; b < 2; b++)
    begin
      {buf_underrun, buf_overflow} <= 2'(b + 1);
      repeat (4) @(posedge pclk);
      {buf_underrun, buf_overflow} <= 2'b00;
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'h014, 32'h0, rd, err);
      chk(rd, 32'((2 << b) - 1));
    end
    apb(1'b1, 12'h014, 32'h3, rd, err);
    apb(1'b1, 12'h000, 32'h0, rd, err);
    frame(8'd16);
    apb(1'b0, 12'h014, 32'h0, rd, err);
    chk(rd, 32'h0);
    // half a byte per frame: carried remainder appears on the second gap
    apb(1'b1, 12'h000, 32'h2, rd, err);
    frame(8'd12);
    chk({16'h0, gap}, 32'd12);
    frame(8'd12);
    chk({16'h0, gap}, 32'd13);
    apb(1'b0, 12'h014, 32'h0, rd, err);
    chk(rd, 32'h4);
    test_done();
  end
endmodule
